// File: src/tic_pkg.sv
// constants for the test interrupt counter controller
package tic_pkg;
  // register selects, one per write-only byte register
  localparam logic [1:0] TIC_SEL_FAST_MASK = 2'h0;
  localparam logic [1:0] TIC_SEL_NORM_MASK = 2'h1;
  localparam logic [1:0] TIC_SEL_FAST_CNT = 2'h2;
  localparam logic [1:0] TIC_SEL_NORM_CNT = 2'h3;
  // mask bit positions
  localparam int TIC_BIT_PARALLEL = 0;
  localparam int TIC_BIT_SERIAL1 = 1;
  localparam int TIC_BIT_SERIAL2 = 2;
  localparam int TIC_BIT_NETWORK = 3;
  localparam int TIC_BIT_TIMER1 = 4;
  localparam int TIC_BIT_TIMER2 = 5;
  localparam int TIC_BIT_SOCKET = 6;
  localparam int TIC_BIT_COUNTER = 7;
  // counter values, mask reset value and read value
  localparam logic [7:0] TIC_CNT_IDLE = 8'hFF;
  localparam logic [7:0] TIC_CNT_ZERO = 8'h00;
  localparam logic [7:0] TIC_CNT_ONE = 8'h01;
  localparam logic [7:0] TIC_RST_VAL = 8'h00;
  localparam logic [7:0] TIC_READ_VAL = 8'h00;
endpackage

// File: src/tic_ctl.sv
// test interrupt counter controller: masks, cycle counters, interrupt lines
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
module tic_ctl
  import tic_pkg::*;
#(
  parameter int DATA_W = 8                // register width
) (
  input  wire logic ref_clk_i,            // bus clock, 40 MHz
  input  wire logic rst_n_i,              // synchronous reset, active low
  input  wire logic wr_i,                 // byte write strobe, one cycle
  input  wire logic rd_i,                 // byte read strobe
  input  wire logic [1:0] sel_i,          // register select
  input  wire logic [DATA_W-1:0] wdata_i, // write data
  output logic [DATA_W-1:0] rdata_o,      // read data, always zero
  input  wire logic socket_a_i,           // card socket A request
  input  wire logic socket_b_i,           // card socket B request
  input  wire logic timer2_i,             // interval timer channel 2
  input  wire logic timer1_i,             // interval timer channel 1
  input  wire logic network_i,            // network controller
  input  wire logic serial2_i,            // second serial port
  input  wire logic serial1_i,            // first serial port
  input  wire logic parallel_i,           // parallel printer port
  output logic norm_irq_o,                // normal interrupt, active high
  output logic fast_irq_o                 // fast interrupt, active high
);

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (DATA_W != 8) begin : g_bad_width
    $error("tic_ctl serves byte registers only");
  end

  logic [7:0] norm_mask_q;
  logic [7:0] fast_mask_q;
  logic [7:0] norm_cnt_q;
  logic [7:0] fast_cnt_q;
  logic norm_pend_q;
  logic fast_pend_q;
  logic [6:0] src;
  logic [7:0] norm_vec;
  logic [7:0] fast_vec;
  logic norm_irq_q;
  logic fast_irq_q;
  logic wr_nmask;
  logic wr_fmask;
  logic wr_ncnt;
  logic wr_fcnt;

  // ---------------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------------
  assign wr_nmask = wr_i && (sel_i == TIC_SEL_NORM_MASK);
  assign wr_fmask = wr_i && (sel_i == TIC_SEL_FAST_MASK);
  assign wr_ncnt = wr_i && (sel_i == TIC_SEL_NORM_CNT);
  assign wr_fcnt = wr_i && (sel_i == TIC_SEL_FAST_CNT);

  // write-only registers: nothing is selected for reads, bus sees zero
  assign rdata_o = TIC_READ_VAL;

  // a read must never expose mask or counter contents
  read_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i |-> rdata_o == TIC_READ_VAL)
    else $error("read returned data");

  // ---------------------------------------------------------------------------
  // source vector
  // ---------------------------------------------------------------------------
  always_comb begin
    src = '0;
    src[TIC_BIT_SOCKET] = socket_a_i | socket_b_i;
    src[TIC_BIT_TIMER2] = timer2_i;
    src[TIC_BIT_TIMER1] = timer1_i;
    src[TIC_BIT_NETWORK] = network_i;
    src[TIC_BIT_SERIAL2] = serial2_i;
    src[TIC_BIT_SERIAL1] = serial1_i;
    src[TIC_BIT_PARALLEL] = parallel_i;
  end

  // ---------------------------------------------------------------------------
  // masks
  // ---------------------------------------------------------------------------
  // contents are undefined to software; reset to zero for a clean simulation
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      norm_mask_q <= TIC_RST_VAL;
      fast_mask_q <= TIC_RST_VAL;
    end else begin
      if (wr_nmask) begin
        norm_mask_q <= wdata_i;
      end
      if (wr_fmask) begin
        fast_mask_q <= wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // cycle counters
  // ---------------------------------------------------------------------------
  // a write wins over the count; 0xFF is the idle hold value
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      norm_cnt_q <= TIC_CNT_IDLE;
    end else if (wr_ncnt) begin
      norm_cnt_q <= wdata_i;
    end else if (norm_cnt_q != TIC_CNT_IDLE) begin
      norm_cnt_q <= norm_cnt_q - TIC_CNT_ONE;
    end
  end

  // normal counter: load, step, wrap and idle hold
  norm_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_ncnt |=> norm_cnt_q == $past(wdata_i))
    else $error("normal counter load wrong");

  norm_dec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!wr_ncnt && norm_cnt_q != TIC_CNT_IDLE) |=> norm_cnt_q == $past(norm_cnt_q) - TIC_CNT_ONE)
    else $error("normal counter step wrong");

  norm_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (norm_cnt_q == TIC_CNT_ZERO && !wr_ncnt) |=> norm_cnt_q == TIC_CNT_IDLE)
    else $error("normal counter did not wrap to idle");

  idle_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (norm_cnt_q == TIC_CNT_IDLE && !wr_ncnt)
      |=> norm_cnt_q == TIC_CNT_IDLE && ($stable(norm_pend_q) || !norm_pend_q))
    else $error("idle counter moved");

  // 0xFF parks the counter without ever passing through zero
  norm_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_ncnt && wdata_i == TIC_CNT_IDLE && norm_cnt_q != TIC_CNT_ZERO && !norm_pend_q)
      |=> norm_cnt_q == TIC_CNT_IDLE && !norm_pend_q)
    else $error("idle write raised a normal interrupt");

  norm_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_ncnt && wdata_i == TIC_CNT_ZERO) |=> norm_cnt_q == TIC_CNT_ZERO ##1 norm_pend_q)
    else $error("normal zero load did not fire");

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fast_cnt_q <= TIC_CNT_IDLE;
    end else if (wr_fcnt) begin
      fast_cnt_q <= wdata_i;
    end else if (fast_cnt_q != TIC_CNT_IDLE) begin
      fast_cnt_q <= fast_cnt_q - TIC_CNT_ONE;
    end
  end

  // fast counter: same checks as the normal one
  fast_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_fcnt |=> fast_cnt_q == $past(wdata_i))
    else $error("fast counter load wrong");

  fast_dec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!wr_fcnt && fast_cnt_q != TIC_CNT_IDLE) |=> fast_cnt_q == $past(fast_cnt_q) - TIC_CNT_ONE)
    else $error("fast counter step wrong");

  fast_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fast_cnt_q == TIC_CNT_ZERO && !wr_fcnt) |=> fast_cnt_q == TIC_CNT_IDLE)
    else $error("fast counter did not wrap to idle");

  fast_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fast_cnt_q == TIC_CNT_IDLE && !wr_fcnt)
      |=> fast_cnt_q == TIC_CNT_IDLE && ($stable(fast_pend_q) || !fast_pend_q))
    else $error("idle fast counter moved");

  fast_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_fcnt && wdata_i == TIC_CNT_IDLE && fast_cnt_q != TIC_CNT_ZERO && !fast_pend_q)
      |=> fast_cnt_q == TIC_CNT_IDLE && !fast_pend_q)
    else $error("idle write raised a fast interrupt");

  fast_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_fcnt && wdata_i == TIC_CNT_ZERO) |=> fast_cnt_q == TIC_CNT_ZERO ##1 fast_pend_q)
    else $error("fast zero load did not fire");

  // ---------------------------------------------------------------------------
  // pending counter interrupts
  // ---------------------------------------------------------------------------
  // set wins over a same-cycle clear so a terminal count is never lost
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      norm_pend_q <= 1'b0;
    end else if (norm_cnt_q == TIC_CNT_ZERO) begin
      norm_pend_q <= 1'b1;
    end else if (wr_nmask && wdata_i[TIC_BIT_COUNTER]) begin
      norm_pend_q <= 1'b0;
    end
  end

  // normal pending: set at zero, cleared only by a mask write with bit 7
  norm_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    norm_cnt_q == TIC_CNT_ZERO |=> norm_pend_q)
    else $error("normal pending not set at zero");

  norm_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_nmask && wdata_i[TIC_BIT_COUNTER] && norm_cnt_q != TIC_CNT_ZERO) |=> !norm_pend_q)
    else $error("normal pending not cleared");

  norm_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (norm_cnt_q != TIC_CNT_ZERO && !(wr_nmask && wdata_i[TIC_BIT_COUNTER]))
      |=> $stable(norm_pend_q))
    else $error("normal pending changed on its own");

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fast_pend_q <= 1'b0;
    end else if (fast_cnt_q == TIC_CNT_ZERO) begin
      fast_pend_q <= 1'b1;
    end else if (wr_fmask && wdata_i[TIC_BIT_COUNTER]) begin
      fast_pend_q <= 1'b0;
    end
  end

  // fast pending: set at zero, cleared only by a fast mask write with bit 7
  fast_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fast_cnt_q == TIC_CNT_ZERO |=> fast_pend_q)
    else $error("fast pending not set at zero");

  fast_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_fmask && wdata_i[TIC_BIT_COUNTER] && fast_cnt_q != TIC_CNT_ZERO) |=> !fast_pend_q)
    else $error("fast pending not cleared");

  fast_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fast_cnt_q != TIC_CNT_ZERO && !(wr_fmask && wdata_i[TIC_BIT_COUNTER]))
      |=> $stable(fast_pend_q))
    else $error("fast pending changed on its own");

  // ---------------------------------------------------------------------------
  // output gating
  // ---------------------------------------------------------------------------
  assign norm_vec = {norm_pend_q, src} & norm_mask_q;
  assign fast_vec = {fast_pend_q, src} & fast_mask_q;

  // registered lines: one cycle of latency buys glitch-free outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      norm_irq_q <= 1'b0;
      fast_irq_q <= 1'b0;
    end else begin
      norm_irq_q <= |norm_vec;
      fast_irq_q <= |fast_vec;
    end
  end

  assign norm_irq_o = norm_irq_q;
  assign fast_irq_o = fast_irq_q;

  // each line is the registered OR of its enabled sources
  fast_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    norm_irq_o == $past(|norm_vec) && fast_irq_o == $past(|fast_vec))
    else $error("interrupt line mismatch");

  norm_line_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (norm_pend_q && norm_mask_q[TIC_BIT_COUNTER]) |=> norm_irq_o)
    else $error("pending normal count not shown");

  fast_line_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fast_pend_q && fast_mask_q[TIC_BIT_COUNTER]) |=> fast_irq_o)
    else $error("pending fast count not shown");

  norm_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (norm_mask_q == '0) |=> !norm_irq_o)
    else $error("blocked normal line raised");

  fast_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fast_mask_q == '0) |=> !fast_irq_o)
    else $error("blocked fast line raised");

  // either socket alone must reach both lines through bit 6
  socket_or_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (norm_mask_q[TIC_BIT_SOCKET] && (socket_a_i || socket_b_i)) |=> norm_irq_o)
    else $error("socket request not routed");

  fast_sock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fast_mask_q[TIC_BIT_SOCKET] && (socket_a_i || socket_b_i)) |=> fast_irq_o)
    else $error("socket request not routed to fast line");

  // per-source routing, one pair of checks for each plain source bit
  for (genvar g = 0; g < TIC_BIT_COUNTER; g++) begin : g_route
    norm_route_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (norm_mask_q[g] && src[g]) |=> norm_irq_o)
      else $error("enabled source missing on normal line");
    fast_route_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (fast_mask_q[g] && src[g]) |=> fast_irq_o)
      else $error("enabled source missing on fast line");
  end

endmodule

// File: verification/tic_cpu_model.sv
// processor-side model that writes and reads the controller's byte registers
`timescale 1ns/1ps
module tic_cpu_model
  import tic_pkg::*;
(
  input wire logic clk_i,         // bus clock
  input wire logic [7:0] rdata_i, // read data from the controller
  output logic wr_o,              // byte write strobe
  output logic rd_o,              // byte read strobe
  output logic [1:0] sel_o,       // register select
  output logic [7:0] wdata_o      // write data
);
  // bus idle at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    sel_o = 2'h0;
    wdata_o = 8'hA5;
  end
  // one byte write, taken at the second edge; data then flips, never holds
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clk_i);
    wr_o <= 1'b1;
    sel_o <= sel;
    wdata_o <= data;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~data;
  endtask
  // one byte read, data taken at the edge that samples the strobe
  task automatic rd(input logic [1:0] sel, output logic [7:0] data);
    @(posedge clk_i);
    rd_o <= 1'b1;
    sel_o <= sel;
    @(posedge clk_i);
    data = rdata_i;
    rd_o <= 1'b0;
  endtask
  // contents are undefined until software clears masks and counters
  task automatic init();
    wr(TIC_SEL_NORM_MASK, 8'h00);
    wr(TIC_SEL_FAST_MASK, 8'h00);
    wr(TIC_SEL_NORM_CNT, 8'h00);
    wr(TIC_SEL_FAST_CNT, 8'h00);
  endtask
endmodule

// File: verification/tb.sv
// self-checking testbench for the test interrupt counter controller
`timescale 1ns/1ps
module tb;
  import tic_pkg::*;
  logic ref_clk_i, rst_n_i, wr, rd, norm_irq, fast_irq;
  logic [1:0] sel;
  logic [7:0] wdata, rdata, src, mn, mf, d;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  // --------------------------------------------------------------
  // design, bus model, clock
  // --------------------------------------------------------------
  tic_ctl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wr_i(wr), .rd_i(rd),
    .sel_i(sel), .wdata_i(wdata), .rdata_o(rdata), .socket_a_i(src[6]),
    .socket_b_i(src[7]), .timer2_i(src[5]), .timer1_i(src[4]), .network_i(src[3]),
    .serial2_i(src[2]), .serial1_i(src[1]), .parallel_i(src[0]),
    .norm_irq_o(norm_irq), .fast_irq_o(fast_irq));
  tic_cpu_model u_cpu (.clk_i(ref_clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .sel_o(sel), .wdata_o(wdata));
  // 40 MHz bus clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // --------------------------------------------------------------
  // checks and expectations
  // --------------------------------------------------------------
  task automatic chk(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // sockets share mask bit 6; bit 7 is the counter, kept clear here
  function automatic logic exp_irq(input logic [7:0] s, input logic [7:0] m);
    logic [7:0] v;
    v = {1'b0, s[6] | s[7], s[5:0]};
    return |(v & m);
  endfunction
  // load a counter and watch its line; idle value 0xFF must never fire
  task automatic run_cnt(input bit p, input logic [7:0] n, input bit en);
    logic [1:0] ms;
    logic exp;
    ms = p ? TIC_SEL_FAST_MASK : TIC_SEL_NORM_MASK;
    u_cpu.wr(ms, {en, 7'h00});
    repeat (3) @(posedge ref_clk_i);
    u_cpu.wr(p ? TIC_SEL_FAST_CNT : TIC_SEL_NORM_CNT, n);
    for (int k = 1; k <= n + 6; k++) begin
      @(posedge ref_clk_i);
      #1;
      exp = en && n != TIC_CNT_IDLE && k >= n + 2;
      chk("cnt_irq", exp, p ? fast_irq : norm_irq);
    end
    u_cpu.wr(ms, 8'h80);
    for (int k = 1; k <= 12; k++) begin
      @(posedge ref_clk_i);
      #1;
      chk("cnt_clear", 1'b0, p ? fast_irq : norm_irq);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    src = 8'h00;
    rst_n_i = 1'b0;
    void'($urandom(31));
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    u_cpu.init();
    // source routing, sockets alone first, then random masks and sources
    for (int i = 0; i < 160; i++) begin
      @(posedge ref_clk_i);
      src <= (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : 8'($urandom);
      mn = (i < 2) ? 8'h40 : {1'b0, 7'($urandom)};
      mf = (i < 2) ? 8'h40 : {1'b0, 7'($urandom)};
      u_cpu.wr(TIC_SEL_NORM_MASK, mn);
      u_cpu.wr(TIC_SEL_FAST_MASK, mf);
      @(posedge ref_clk_i);
      #1;
      chk("norm_irq", exp_irq(src, mn), norm_irq);
      chk("fast_irq", exp_irq(src, mf), fast_irq);
    end
    // reads return nothing, even with masks loaded
    for (int s = 0; s < 4; s++) begin
      u_cpu.rd(2'(s), d);
      chk8("rdata", 8'h00, d);
    end
    @(posedge ref_clk_i);
    src <= 8'h00;
    u_cpu.wr(TIC_SEL_NORM_MASK, 8'h00);
    u_cpu.wr(TIC_SEL_FAST_MASK, 8'h00);
    // counters at boundary values, a random count and a masked run
    for (int p = 0; p < 2; p++) begin
      run_cnt(p[0], 8'h00, 1'b1);
      run_cnt(p[0], 8'h01, 1'b1);
      run_cnt(p[0], 8'hFE, 1'b1);
      run_cnt(p[0], 8'hFF, 1'b1);
      run_cnt(p[0], 8'($urandom_range(2, 253)), 1'b1);
      run_cnt(p[0], 8'h03, 1'b0);
    end
    end_sim();
  end
endmodule
